/* File: verilog/timer_pkg.sv */
// Shared constants and types of the reload counter timer block.
`default_nettype none
package timer_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [7:0] RUN_CONTROL_OFS = 8'h0E;
  localparam logic [7:0] FIRST_TIMER_CONTROL_OFS = 8'h0F;
  localparam logic [7:0] FIRST_TIMER_RELOAD_UPPER_OFS = 8'h10;
  localparam logic [7:0] FIRST_TIMER_RELOAD_LOWER_OFS = 8'h11;
  localparam logic [7:0] FIRST_TIMER_COUNT_UPPER_OFS = 8'h12;
  localparam logic [7:0] FIRST_TIMER_COUNT_LOWER_OFS = 8'h13;
  localparam logic [7:0] SECOND_TIMER_CONTROL_OFS = 8'h14;
  localparam logic [7:0] SECOND_TIMER_RELOAD_UPPER_OFS = 8'h15;
  localparam logic [7:0] SECOND_TIMER_RELOAD_LOWER_OFS = 8'h16;
  localparam logic [7:0] SECOND_TIMER_COUNT_UPPER_OFS = 8'h17;
  localparam logic [7:0] SECOND_TIMER_COUNT_LOWER_OFS = 8'h18;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h21;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int CTRL_STOP_RX_BIT = 7;
  localparam int CTRL_START_LSB = 4;
  localparam int CTRL_AUTO_RELOAD_BIT = 3;
  localparam int CTRL_CLK_LSB = 0;
  localparam int RUN_ACTIVE_LSB = 4;
  localparam int RUN_MASK_LSB = 0;
  localparam int IRQ_FIRST_BIT = 0;
  localparam int IRQ_SECOND_BIT = 1;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [7:0] READ_IDLE = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Encodings.
  typedef enum logic [1:0] {
    START_NONE = 2'h0,
    START_TX_END = 2'h1,
    START_LFO_NO_UNDERFLOW = 2'h2,
    START_LFO_UNDERFLOW = 2'h3
  } start_src_t;

  typedef enum logic [1:0] {
    CLK_FAST = 2'h0,
    CLK_SLOW = 2'h1,
    CLK_CASCADE_A = 2'h2,
    CLK_CASCADE_B = 2'h3
  } clk_sel_t;

  typedef struct packed {
    logic stop_on_receive;
    start_src_t start_source;
    logic auto_reload;
    clk_sel_t clock_select;
  } timer_cfg_t;

  typedef struct packed {
    logic tick_fast;
    logic tick_slow;
    logic cascade_a;
    logic cascade_b;
    logic tx_end;
    logic rx_first_bits;
    logic lfo_rise;
  } timer_events_t;

  typedef struct packed {
    logic set;
    logic clear;
  } run_cmd_t;

endpackage : timer_pkg
`default_nettype wire

/* File: verilog/reload_down_counter.sv */
// One 16-bit down-counter with reload, start sources and clock selection.
`default_nettype none
`timescale 1ns/100ps
module reload_down_counter (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire timer_pkg::timer_cfg_t cfg_i,
  input wire logic [15:0] reload_i,
  input wire timer_pkg::timer_events_t ev_i,
  input wire timer_pkg::run_cmd_t run_cmd_i,
  output logic [15:0] count_o,
  output logic running_o,
  output logic underflow_o
);

  logic lfo_mode;
  logic tick;
  logic stop_rx;
  logic start;

  assign lfo_mode = cfg_i.start_source[1];
  // Trimming modes ignore the stop-on-receive setting.
  assign stop_rx = cfg_i.stop_on_receive & ~lfo_mode & ev_i.rx_first_bits;
  assign start = ((cfg_i.start_source == timer_pkg::START_TX_END)
                  & ev_i.tx_end)
                 | (lfo_mode & ev_i.lfo_rise & ~running_o);

  always_comb begin
    unique case (cfg_i.clock_select)
      timer_pkg::CLK_FAST: tick = ev_i.tick_fast;
      timer_pkg::CLK_SLOW: tick = ev_i.tick_slow;
      timer_pkg::CLK_CASCADE_A: tick = ev_i.cascade_a;
      timer_pkg::CLK_CASCADE_B: tick = ev_i.cascade_b;
    endcase
  end

  // Software stop wins over every hardware event, then stops, then starts.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_o <= timer_pkg::COUNT_RESET;
      running_o <= 1'b0;
      underflow_o <= 1'b0;
    end else begin
      underflow_o <= 1'b0;
      if (run_cmd_i.clear) begin
        running_o <= 1'b0;
      end else if (stop_rx) begin
        running_o <= 1'b0;
      end else if (lfo_mode && ev_i.lfo_rise && running_o) begin
        running_o <= 1'b0;
      end else if (start || run_cmd_i.set) begin
        count_o <= reload_i;
        running_o <= 1'b1;
      end else if (running_o && tick) begin
        if (count_o != 16'h0000) begin
          count_o <= count_o - 16'h0001;
        end else if (cfg_i.start_source == timer_pkg::START_LFO_NO_UNDERFLOW) begin
          running_o <= 1'b0;
        end else begin
          underflow_o <= 1'b1;
          if (cfg_i.auto_reload) begin
            count_o <= reload_i;
          end else begin
            running_o <= 1'b0;
          end
        end
      end
    end
  end

endmodule : reload_down_counter
`default_nettype wire

/* File: verilog/reader_timer01_reload_counter.sv */
// Register file and event logic for the first two reader timers.
//
// Functional notes
// - Start event loads full 16-bit reload value.
// - Reload writes affect only the next start or auto-reload.
// - Reload high byte at lower address.
// - Count high byte reads live upper bits.
// - Count low byte reads live lower bits.
// - Stop-on-receive halts timer after four bits.
// - Trimming modes ignore stop-on-receive.
// - Start source none or end of transmission.
// - Codes 10/11 trim oscillator on rising edge.
// - Auto-reload restarts count at zero except in start code 10.
// - Without auto-reload timer halts at zero.
// - Second timer underflow sets its interrupt flag.
// - Clock codes pick 13.56 MHz or 211.875 kHz.
// - Clock codes 10/11 cascade other timers.
// - Run bits change only where mask written.
// - Run bits show and control counting.
`default_nettype none
`timescale 1ns/100ps
module reader_timer01_reload_counter (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic tick_fast_pin_i,
  input wire logic tick_slow_pin_i,
  input wire logic lfo_pin_i,
  input wire logic tx_end_i,
  input wire logic rx_first_bits_i,
  input wire logic third_timer_underflow_i,
  output logic [7:0] rd_data_o,
  output logic irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [2:0] sync_a_r;
  logic [2:0] sync_b_r;
  logic [2:0] sync_c_r;
  logic [2:0] last_r;
  logic [2:0] rise;

  // The first stage is read only by the second; edges use the second stage.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_a_r <= 3'h0;
      sync_b_r <= 3'h0;
      last_r <= 3'h0;
    end else begin
      sync_a_r <= {lfo_pin_i, tick_slow_pin_i, tick_fast_pin_i};
      sync_b_r <= sync_a_r;
      last_r <= sync_b_r;
    end
  end

  assign sync_c_r = sync_b_r;
  assign rise = sync_c_r & ~last_r;

  //////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic [7:0] first_ctrl_r;
  logic [7:0] second_ctrl_r;
  logic [15:0] first_reload_r;
  logic [15:0] second_reload_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_status_nxt;
  logic [1:0] irq_mask_r;
  logic [7:0] rd_data_r;
  logic irq_r;

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_i && (addr_i == ofs);
  endfunction : wr_hit

  function automatic timer_pkg::timer_cfg_t to_cfg(input logic [7:0] b);
    timer_pkg::timer_cfg_t c;
    c.stop_on_receive = b[timer_pkg::CTRL_STOP_RX_BIT];
    c.start_source = timer_pkg::start_src_t'(b[timer_pkg::CTRL_START_LSB +: 2]);
    c.auto_reload = b[timer_pkg::CTRL_AUTO_RELOAD_BIT];
    c.clock_select = timer_pkg::clk_sel_t'(b[timer_pkg::CTRL_CLK_LSB +: 2]);
    to_cfg = c;
  endfunction : to_cfg

  // Reserved control bits 6 and 2 are not stored and read as zero.
  function automatic logic [7:0] ctrl_view(input logic [7:0] b);
    ctrl_view = b & 8'hBB;
  endfunction : ctrl_view

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_ctrl_r <= timer_pkg::CONTROL_RESET;
      second_ctrl_r <= timer_pkg::CONTROL_RESET;
    end else begin
      if (wr_hit(timer_pkg::FIRST_TIMER_CONTROL_OFS)) begin
        first_ctrl_r <= ctrl_view(wr_data_i);
      end
      if (wr_hit(timer_pkg::SECOND_TIMER_CONTROL_OFS)) begin
        second_ctrl_r <= ctrl_view(wr_data_i);
      end
    end
  end

  // Reload bytes only feed the counter on a start or an auto-reload, never the live count.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_reload_r <= timer_pkg::RELOAD_RESET;
      second_reload_r <= timer_pkg::RELOAD_RESET;
    end else begin
      if (wr_hit(timer_pkg::FIRST_TIMER_RELOAD_UPPER_OFS)) begin
        first_reload_r[15:8] <= wr_data_i;
      end
      if (wr_hit(timer_pkg::FIRST_TIMER_RELOAD_LOWER_OFS)) begin
        first_reload_r[7:0] <= wr_data_i;
      end
      if (wr_hit(timer_pkg::SECOND_TIMER_RELOAD_UPPER_OFS)) begin
        second_reload_r[15:8] <= wr_data_i;
      end
      if (wr_hit(timer_pkg::SECOND_TIMER_RELOAD_LOWER_OFS)) begin
        second_reload_r[7:0] <= wr_data_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Masked run control.

  logic run_wr;
  timer_pkg::run_cmd_t first_cmd;
  timer_pkg::run_cmd_t second_cmd;

  assign run_wr = wr_hit(timer_pkg::RUN_CONTROL_OFS);

  function automatic timer_pkg::run_cmd_t run_cmd(input int idx);
    timer_pkg::run_cmd_t r;
    logic en;
    logic val;
    en = run_wr && wr_data_i[timer_pkg::RUN_MASK_LSB + idx];
    val = wr_data_i[timer_pkg::RUN_ACTIVE_LSB + idx];
    r.set = en & val;
    r.clear = en & ~val;
    run_cmd = r;
  endfunction : run_cmd

  assign first_cmd = run_cmd(0);
  assign second_cmd = run_cmd(1);

  //////////////////////////////////////////////////////////////////////////////
  // The two timers.

  logic [15:0] first_count;
  logic [15:0] second_count;
  logic first_running;
  logic second_running;
  logic first_underflow;
  logic second_underflow;
  timer_pkg::timer_events_t first_ev;
  timer_pkg::timer_events_t second_ev;

  // The first timer cascades from the third timer or the second timer.
  assign first_ev = '{
    tick_fast: rise[0],
    tick_slow: rise[1],
    cascade_a: third_timer_underflow_i,
    cascade_b: second_underflow,
    tx_end: tx_end_i,
    rx_first_bits: rx_first_bits_i,
    lfo_rise: rise[2]
  };

  assign second_ev = '{
    tick_fast: rise[0],
    tick_slow: rise[1],
    cascade_a: first_underflow,
    cascade_b: third_timer_underflow_i,
    tx_end: tx_end_i,
    rx_first_bits: rx_first_bits_i,
    lfo_rise: rise[2]
  };

  reload_down_counter first_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .cfg_i(to_cfg(first_ctrl_r)),
    .reload_i(first_reload_r),
    .ev_i(first_ev),
    .run_cmd_i(first_cmd),
    .count_o(first_count),
    .running_o(first_running),
    .underflow_o(first_underflow)
  );

  reload_down_counter second_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .cfg_i(to_cfg(second_ctrl_r)),
    .reload_i(second_reload_r),
    .ev_i(second_ev),
    .run_cmd_i(second_cmd),
    .count_o(second_count),
    .running_o(second_running),
    .underflow_o(second_underflow)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  logic [1:0] irq_events;
  logic [1:0] irq_w1c;

  assign irq_events = {second_underflow, first_underflow};
  assign irq_w1c = wr_hit(timer_pkg::IRQ_STATUS_OFS) ? wr_data_i[1:0] : 2'h0;
  // A set in the same cycle as its clear keeps the flag.
  assign irq_status_nxt = (irq_status_r & ~irq_w1c) | irq_events;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status_r <= timer_pkg::IRQ_RESET;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask_r <= timer_pkg::IRQ_RESET;
    end else if (wr_hit(timer_pkg::IRQ_MASK_OFS)) begin
      irq_mask_r <= wr_data_i[1:0];
    end
  end

  // Uses the next status so that the line rises with the flag.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_status_nxt & irq_mask_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [7:0] rd_mux;

  // Count bytes are sampled live; a multi-byte read is not atomic.
  always_comb begin
    rd_mux = timer_pkg::READ_IDLE;
    unique case (addr_i)
      timer_pkg::RUN_CONTROL_OFS:
        rd_mux = {2'h0, second_running, first_running, 4'h0};
      timer_pkg::FIRST_TIMER_CONTROL_OFS: rd_mux = first_ctrl_r;
      timer_pkg::FIRST_TIMER_RELOAD_UPPER_OFS: rd_mux = first_reload_r[15:8];
      timer_pkg::FIRST_TIMER_RELOAD_LOWER_OFS: rd_mux = first_reload_r[7:0];
      timer_pkg::FIRST_TIMER_COUNT_UPPER_OFS: rd_mux = first_count[15:8];
      timer_pkg::FIRST_TIMER_COUNT_LOWER_OFS: rd_mux = first_count[7:0];
      timer_pkg::SECOND_TIMER_CONTROL_OFS: rd_mux = second_ctrl_r;
      timer_pkg::SECOND_TIMER_RELOAD_UPPER_OFS: rd_mux = second_reload_r[15:8];
      timer_pkg::SECOND_TIMER_RELOAD_LOWER_OFS: rd_mux = second_reload_r[7:0];
      timer_pkg::SECOND_TIMER_COUNT_UPPER_OFS: rd_mux = second_count[15:8];
      timer_pkg::SECOND_TIMER_COUNT_LOWER_OFS: rd_mux = second_count[7:0];
      timer_pkg::IRQ_STATUS_OFS: rd_mux = {6'h00, irq_status_r};
      timer_pkg::IRQ_MASK_OFS: rd_mux = {6'h00, irq_mask_r};
      default: rd_mux = timer_pkg::READ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_r <= timer_pkg::READ_IDLE;
    end else begin
      rd_data_r <= rd_i ? rd_mux : timer_pkg::READ_IDLE;
    end
  end

  assign rd_data_o = rd_data_r;
  assign irq_o = irq_r;

endmodule : reader_timer01_reload_counter
`default_nettype wire

/* File: verification/reader_timer01_reload_counter_checker.sv */
// Concurrent checks on the register port of the reader timer block.
`timescale 1ns/100ps
`default_nettype none
module reader_timer01_reload_counter_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic tick_fast_pin_i,
  input wire logic tick_slow_pin_i,
  input wire logic lfo_pin_i,
  input wire logic tx_end_i,
  input wire logic rx_first_bits_i,
  input wire logic third_timer_underflow_i,
  input wire logic [7:0] rd_data_o,
  input wire logic irq_o
);
  logic [7:0] h0_r, l0_r, h1_r, l1_r, ctl_r;
  logic [1:0] msk_r;
  logic [2:0] quiet_r;
  logic busy;
  // Any event input may move the count, so count checks wait for a lull.
  assign busy = tick_fast_pin_i | tick_slow_pin_i | lfo_pin_i | tx_end_i
    | rx_first_bits_i | third_timer_underflow_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {h0_r, l0_r, h1_r, l1_r, ctl_r} <= 40'h0;
      msk_r <= 2'h0;
    end else if (wr_i) begin
      case (addr_i)
        8'h10: h0_r <= wr_data_i;
        8'h11: l0_r <= wr_data_i;
        8'h14: ctl_r <= wr_data_i;
        8'h15: h1_r <= wr_data_i;
        8'h16: l1_r <= wr_data_i;
        8'h21: msk_r <= wr_data_i[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) quiet_r <= 3'h0;
    else if (busy) quiet_r <= 3'h0;
    else quiet_r <= quiet_r + {2'h0, quiet_r != 3'h7};
  end

  ////////////////////////////////////////////////////////////
  property p_rel_h0;
    logic [7:0] v;
    (rd_i && addr_i == 8'h10, v = h0_r) |=> rd_data_o == v;
  endproperty
  a_rel_h0: assert property (p_rel_h0)
    else $error("first reload upper readback differs");
  property p_rel_l0;
    logic [7:0] v;
    (rd_i && addr_i == 8'h11, v = l0_r) |=> rd_data_o == v;
  endproperty
  a_rel_l0: assert property (p_rel_l0)
    else $error("first reload lower readback differs");
  property p_rel_h1;
    logic [7:0] v;
    (rd_i && addr_i == 8'h15, v = h1_r) |=> rd_data_o == v;
  endproperty
  a_rel_h1: assert property (p_rel_h1)
    else $error("second reload upper readback differs");
  property p_rel_l1;
    logic [7:0] v;
    (rd_i && addr_i == 8'h16, v = l1_r) |=> rd_data_o == v;
  endproperty
  a_rel_l1: assert property (p_rel_l1)
    else $error("second reload lower readback differs");
  property p_ctl;
    logic [7:0] v;
    (rd_i && addr_i == 8'h14, v = ctl_r) |=> rd_data_o == (v & 8'hBB);
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("second control readback differs");
  property p_load;
    logic [7:0] v;
    (wr_i && addr_i == 8'h0E && wr_data_i[5] && wr_data_i[1] && !ctl_r[1],
      v = h1_r) ##2 (rd_i && addr_i == 8'h17 && quiet_r == 3'h7)
      |=> rd_data_o == v;
  endproperty
  a_load: assert property (p_load)
    else $error("start did not load the reload upper byte");
  property p_run_set;
    (wr_i && addr_i == 8'h0E && wr_data_i[5] && wr_data_i[1])
      ##2 (rd_i && addr_i == 8'h0E && quiet_r == 3'h7)
      |=> rd_data_o[5] && rd_data_o[1:0] == 2'h0;
  endproperty
  a_run_set: assert property (p_run_set)
    else $error("masked run set not shown");
  property p_run_clr;
    (wr_i && addr_i == 8'h0E && !wr_data_i[5] && wr_data_i[1])
      ##2 (rd_i && addr_i == 8'h0E && quiet_r == 3'h7) |=> !rd_data_o[5];
  endproperty
  a_run_clr: assert property (p_run_clr)
    else $error("masked run clear not shown");
  property p_irq_masked;
    (msk_r == 2'h0 && $past(msk_r) == 2'h0) |-> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt high with all sources masked");
endmodule : reader_timer01_reload_counter_checker

bind reader_timer01_reload_counter reader_timer01_reload_counter_checker
  chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
  .tick_fast_pin_i(tick_fast_pin_i), .tick_slow_pin_i(tick_slow_pin_i),
  .lfo_pin_i(lfo_pin_i), .tx_end_i(tx_end_i),
  .rx_first_bits_i(rx_first_bits_i),
  .third_timer_underflow_i(third_timer_underflow_i),
  .rd_data_o(rd_data_o), .irq_o(irq_o));
`default_nettype wire

/* File: verification/reader_timer01_reload_counter_bench.sv */
// Self-checking bench of the reader timer reload counter block.
`timescale 1ns/100ps
`default_nettype none
module reader_timer01_reload_counter_bench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rd_data, v;
  logic wr = 1'b0, rd = 1'b0, irq;
  // Bits: fast, slow, lfo, tx end, first bits, third underflow.
  logic [5:0] ev = 6'h00;
  logic [15:0] rl;
  logic [7:0] rw_ofs [4] = '{8'h10, 8'h11, 8'h15, 8'h16};
  int errors = 0, n_tests = 0, seed = 32'h447a;

  reader_timer01_reload_counter uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wr_data_i(wdata),
    .wr_i(wr), .rd_i(rd), .tick_fast_pin_i(ev[0]), .tick_slow_pin_i(ev[1]),
    .lfo_pin_i(ev[2]), .tx_end_i(ev[3]), .rx_first_bits_i(ev[4]),
    .third_timer_underflow_i(ev[5]), .rd_data_o(rd_data), .irq_o(irq)
  );

  initial forever #2.5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(rd_data, exp);
  endtask : rreg

  // Pins pass a synchroniser, so each pulse is followed by a settle gap.
  task automatic pulse(input int i, input int len);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    repeat (len) @(posedge clk_i);
    ev[i] <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : pulse

  task automatic load1(input logic [7:0] c, input logic [15:0] r);
    wreg(8'h14, c);
    wreg(8'h15, r[15:8]);
    wreg(8'h16, r[7:0]);
  endtask : load1

  task automatic cnt1(input logic [15:0] e);
    rreg(8'h17, e[15:8]);
    rreg(8'h18, e[7:0]);
  endtask : cnt1

  // Reserved control bits 6 and 2 always read as zero.
  function automatic logic [7:0] ctrl_view(input logic [7:0] c);
    return c & 8'hBB;
  endfunction : ctrl_view

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int a = 16; a < 25; a++) rreg(8'(a), 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      wreg(rw_ofs[i % 4], v);
      rreg(rw_ofs[i % 4], v);
    end
    wreg(8'h12, 8'h5A);
    wreg(8'h13, 8'hA5);
    rreg(8'h12, 8'h00);
    rreg(8'h13, 8'h00);
    v = 8'($random(seed));
    wreg(8'h14, v);
    rreg(8'h14, ctrl_view(v));
    wreg(8'h21, 8'h02);
    load1(8'h00, 16'h0003);
    wreg(8'h0E, 8'h22);
    rreg(8'h0E, 8'h20);
    cnt1(16'h0003);
    rl = 16'($random(seed));
    wreg(8'h15, rl[15:8]);
    wreg(8'h16, rl[7:0]);
    cnt1(16'h0003);
    pulse(0, 2);
    cnt1(16'h0002);
    pulse(0, 2);
    pulse(0, 2);
    cnt1(16'h0000);
    rreg(8'h20, 8'h00);
    pulse(0, 2);
    rreg(8'h20, 8'h02);
    chk({7'h00, irq}, 8'h01);
    rreg(8'h0E, 8'h00);
    cnt1(16'h0000);
    wreg(8'h20, 8'h02);
    // The line is launched by the edge that ends the write, so wait for it.
    #1 chk({7'h00, irq}, 8'h00);
    load1(8'h08, 16'h0001);
    wreg(8'h0E, 8'h22);
    cnt1(16'h0001);
    pulse(0, 2);
    pulse(0, 2);
    cnt1(16'h0001);
    rreg(8'h0E, 8'h20);
    wreg(8'h0E, 8'h00);
    rreg(8'h0E, 8'h20);
    wreg(8'h0E, 8'h02);
    rreg(8'h0E, 8'h00);
    pulse(0, 2);
    cnt1(16'h0001);
    load1(8'h01, 16'h0010);
    wreg(8'h0E, 8'h22);
    pulse(0, 2);
    pulse(1, 2);
    cnt1(16'h000F);
    load1(8'h03, 16'h0010);
    wreg(8'h0E, 8'h22);
    pulse(5, 1);
    pulse(1, 2);
    cnt1(16'h000F);
    wreg(8'h14, 8'h02);
    wreg(8'h10, 8'h00);
    wreg(8'h11, 8'h00);
    // Drop the flag left by the auto-reload underflow before the masked check.
    wreg(8'h20, 8'h02);
    wreg(8'h0E, 8'h11);
    pulse(0, 2);
    cnt1(16'h000E);
    chk({7'h00, irq}, 8'h00);
    rreg(8'h20, 8'h01);
    wreg(8'h0E, 8'h02);
    load1(8'h00, 16'h0005);
    pulse(3, 1);
    rreg(8'h0E, 8'h00);
    wreg(8'h14, 8'h90);
    pulse(3, 1);
    cnt1(16'h0005);
    // Count bytes are never read while the first bits arrive.
    pulse(4, 1);
    rreg(8'h0E, 8'h00);
    load1(8'hA0, 16'h0002);
    pulse(2, 2);
    cnt1(16'h0002);
    pulse(4, 1);
    rreg(8'h0E, 8'h20);
    pulse(2, 2);
    rreg(8'h0E, 8'h00);
    complete_run();
  end

  // The sequence needs well under a thousand cycles; four thousand is ample.
  initial begin
    #(4000 * 5);
    errors++;
    complete_run();
  end
endmodule : reader_timer01_reload_counter_bench
`default_nettype wire
